// ### hw/mbag_top.sv
// modulo and bit-reversed address generator with apb registers
`timescale 1ns/10ps
`default_nettype none
`include "mbag_defines.svh"
module mbag_top (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [7:0]          paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output var  logic [31:0]         prdata,
	output var  logic                pready,
	output var  logic                pslverr,
	input  wire mbag_pkg::mbag_req_t xr_req,
	input  wire mbag_pkg::mbag_req_t xw_req,
	input  wire mbag_pkg::mbag_req_t y_req,
	output var  mbag_pkg::mbag_res_t xr_res,
	output var  mbag_pkg::mbag_res_t xw_res,
	output var  mbag_pkg::mbag_res_t y_res
);
	logic [15:0]         mode_ctl_ff;
	logic [15:0]         brev_ctl_ff;
	logic [15:0]         x_circ_start_ff;
	logic [15:0]         x_circ_end_ff;
	logic [15:0]         y_circ_start_ff;
	logic [15:0]         y_circ_end_ff;
	logic [31:0]         prdata_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	logic [31:0]         nxt_prdata;
	logic                nxt_hit;
	logic                wr_go;
	logic                rd_go;
	mbag_pkg::mbag_res_t xr_res_ff;
	mbag_pkg::mbag_res_t xw_res_ff;
	mbag_pkg::mbag_res_t y_res_ff;
	mbag_pkg::mbag_res_t nxt_xr;
	mbag_pkg::mbag_res_t nxt_xw;
	mbag_pkg::mbag_res_t nxt_y;

	// control fields
	logic       x_circ_enable;
	logic       y_circ_enable;
	logic [3:0] x_circ_pointer_sel;
	logic [3:0] y_circ_pointer_sel;
	logic [3:0] reverse_pointer_sel;
	logic       reverse_enable;
	logic [14:0] pivot_modifier;

	assign x_circ_enable       = mode_ctl_ff[`MBAG_X_EN_BIT];
	assign y_circ_enable       = mode_ctl_ff[`MBAG_Y_EN_BIT];
	assign x_circ_pointer_sel  = mode_ctl_ff[`MBAG_X_SEL_LSB +: 4];
	assign y_circ_pointer_sel  = mode_ctl_ff[`MBAG_Y_SEL_LSB +: 4];
	assign reverse_pointer_sel = mode_ctl_ff[`MBAG_B_SEL_LSB +: 4];
	assign reverse_enable      = brev_ctl_ff[`MBAG_REV_EN_BIT];
	assign pivot_modifier      = brev_ctl_ff[14:0];

	// one wait state: data is ready on the second access cycle
	assign rd_go = psel && penable && !pready_ff;
	assign wr_go = psel && penable && pready_ff && pwrite && !pslverr_ff;

	// X read unit: circular only, reversal never applies to reads
	mbag_agu_lane #(
		.EVEN_ONLY (1'b0),
		.HAS_BREV  (1'b0)
	) u_xr (
		.req            (xr_req),
		.circ_on        (x_circ_enable),
		.circ_sel       (x_circ_pointer_sel),
		.circ_lo        (x_circ_start_ff),
		.circ_hi        (x_circ_end_ff),
		.rev_on         (1'b0),
		.rev_sel        (reverse_pointer_sel),
		.pivot_modifier (pivot_modifier),
		.res            (nxt_xr)
	);

	// X write unit: reversal takes priority over circular here
	mbag_agu_lane #(
		.EVEN_ONLY (1'b0),
		.HAS_BREV  (1'b1)
	) u_xw (
		.req            (xw_req),
		.circ_on        (x_circ_enable),
		.circ_sel       (x_circ_pointer_sel),
		.circ_lo        (x_circ_start_ff),
		.circ_hi        (x_circ_end_ff),
		.rev_on         (reverse_enable),
		.rev_sel        (reverse_pointer_sel),
		.pivot_modifier (pivot_modifier),
		.res            (nxt_xw)
	);

	// Y unit: word data only, so addresses stay even
	mbag_agu_lane #(
		.EVEN_ONLY (1'b1),
		.HAS_BREV  (1'b0)
	) u_y (
		.req            (y_req),
		.circ_on        (y_circ_enable),
		.circ_sel       (y_circ_pointer_sel),
		.circ_lo        (y_circ_start_ff),
		.circ_hi        (y_circ_end_ff),
		.rev_on         (1'b0),
		.rev_sel        (reverse_pointer_sel),
		.pivot_modifier (pivot_modifier),
		.res            (nxt_y)
	);

	// read mux and address decode
	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		nxt_hit    = 1'b1;
		case (paddr)
			`MBAG_OFF_MODE_CTL: nxt_prdata[15:0] = mode_ctl_ff;
			`MBAG_OFF_BREV_CTL: nxt_prdata[15:0] = brev_ctl_ff;
			`MBAG_OFF_X_START:  nxt_prdata[15:0] = x_circ_start_ff;
			`MBAG_OFF_X_END:    nxt_prdata[15:0] = x_circ_end_ff;
			`MBAG_OFF_Y_START:  nxt_prdata[15:0] = y_circ_start_ff;
			`MBAG_OFF_Y_END:    nxt_prdata[15:0] = y_circ_end_ff;
			`MBAG_OFF_STAT_X:
				nxt_prdata = {xw_res_ff.effective_addr,
					xr_res_ff.effective_addr};
			`MBAG_OFF_STAT_Y:
				nxt_prdata = {12'h000, xw_res_ff.brev, y_res_ff.wrapped,
					xw_res_ff.wrapped, xr_res_ff.wrapped,
					y_res_ff.effective_addr};
			default:            nxt_hit = 1'b0;
		endcase
	end

	// apb answer flops; pready drops after each completed access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			pready_ff  <= rd_go;
			pslverr_ff <= rd_go && !nxt_hit;
			if (rd_go && !pwrite)
				prdata_ff <= nxt_prdata;
			else if (!psel)
				prdata_ff <= 32'h0000_0000;
		end
	end

	// control registers, written at the completing edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_ctl_ff <= `MBAG_RST_MODE_CTL;
			brev_ctl_ff <= `MBAG_RST_BREV_CTL;
		end
		else if (wr_go)
		begin
			if (paddr == `MBAG_OFF_MODE_CTL)
				mode_ctl_ff <= pwdata[15:0];
			if (paddr == `MBAG_OFF_BREV_CTL)
				brev_ctl_ff <= pwdata[15:0];
		end
	end

	// circular boundaries, loaded by software before use
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			x_circ_start_ff <= `MBAG_RST_BOUND;
			x_circ_end_ff   <= `MBAG_RST_BOUND;
			y_circ_start_ff <= `MBAG_RST_BOUND;
			y_circ_end_ff   <= `MBAG_RST_BOUND;
		end
		else if (wr_go)
		begin
			case (paddr)
				`MBAG_OFF_X_START: x_circ_start_ff <= pwdata[15:0];
				`MBAG_OFF_X_END:   x_circ_end_ff   <= pwdata[15:0];
				`MBAG_OFF_Y_START: y_circ_start_ff <= pwdata[15:0];
				`MBAG_OFF_Y_END:   y_circ_end_ff   <= pwdata[15:0];
				default:           x_circ_start_ff <= x_circ_start_ff;
			endcase
		end
	end

	// results registered so every output leaves a flop;
	// costs one cycle of latency but keeps timing clean
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xr_res_ff <= '0;
			xw_res_ff <= '0;
			y_res_ff  <= '0;
		end
		else
		begin
			xr_res_ff <= nxt_xr;
			xw_res_ff <= nxt_xw;
			y_res_ff  <= nxt_y;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign xr_res  = xr_res_ff;
	assign xw_res  = xw_res_ff;
	assign y_res   = y_res_ff;

	// checks; results are judged on the registered lane copies
	chk_y_even_addr: assert property (
		@(posedge pclk) disable iff (!presetn)
		y_res_ff.valid |-> !y_res_ff.effective_addr[0] &&
		!y_res_ff.wb_val[0])
		else $error("odd Y address");

	chk_x_circ_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		xr_res_ff.wrapped |-> $past(mode_ctl_ff[15]) &&
		$past(mode_ctl_ff[3:0]) != 4'hF &&
		$past(xr_req.ptr_sel) == $past(mode_ctl_ff[3:0]))
		else $error("X wrap without enable");

	chk_y_circ_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		y_res_ff.wrapped |-> $past(mode_ctl_ff[14]) &&
		$past(mode_ctl_ff[7:4]) != 4'hF)
		else $error("Y wrap without enable");

	chk_y_wrap_sel: assert property (
		@(posedge pclk) disable iff (!presetn)
		y_res_ff.wrapped |->
		$past(y_req.ptr_sel) == $past(mode_ctl_ff[7:4]))
		else $error("Y wrap on unselected pointer");

	chk_offset_no_wb: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(xr_req.valid) && $past(xr_req.mode) == mbag_pkg::MD_REG_OFFSET
		|-> !xr_res_ff.wb_en)
		else $error("write-back on offset mode");

	chk_xw_offset_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(xw_req.valid) && $past(xw_req.mode) == mbag_pkg::MD_REG_OFFSET
		|-> !xw_res_ff.wb_en)
		else $error("write-back on offset mode in X write");

	chk_xw_wb_modes: assert property (
		@(posedge pclk) disable iff (!presetn)
		xw_res_ff.wb_en |-> $past(xw_req.mode) != mbag_pkg::MD_INDIRECT &&
		$past(xw_req.mode) != mbag_pkg::MD_REG_OFFSET)
		else $error("write-back without modify mode");

	chk_brev_write_only: assert property (
		@(posedge pclk) disable iff (!presetn)
		!xr_res_ff.brev && !y_res_ff.brev)
		else $error("reversal outside X write");

	chk_brev_ptr_normal: assert property (
		@(posedge pclk) disable iff (!presetn)
		xw_res_ff.brev && $past(xw_req.mode) == mbag_pkg::MD_POST_INC
		|-> xw_res_ff.effective_addr == ($past(xw_req.ptr) & 16'hFFFE))
		else $error("reversed post access moved the pointer");

	chk_brev_enable: assert property (
		@(posedge pclk) disable iff (!presetn)
		xw_res_ff.brev |-> $past(brev_ctl_ff[15]) && $past(xw_req.word) &&
		($past(xw_req.mode) == mbag_pkg::MD_PRE_INC ||
		$past(xw_req.mode) == mbag_pkg::MD_POST_INC))
		else $error("reversal without its conditions");

	chk_brev_even: assert property (
		@(posedge pclk) disable iff (!presetn)
		xw_res_ff.brev |-> !xw_res_ff.effective_addr[0] &&
		!xw_res_ff.wb_val[0])
		else $error("odd reversed address");

	chk_brev_priority: assert property (
		@(posedge pclk) disable iff (!presetn)
		xw_res_ff.brev |-> !xw_res_ff.wrapped)
		else $error("wrap during reversal");

	chk_wrap_below_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		xr_res_ff.wrapped && $past(xr_req.mode) == mbag_pkg::MD_POST_INC
		|-> xr_res_ff.wb_val < $past(xr_req.ptr))
		else $error("increment wrap did not go back");

	chk_xstart_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(wr_go) && $past(paddr) == `MBAG_OFF_X_START
		|-> x_circ_start_ff == $past(pwdata[15:0]))
		else $error("X start boundary not loaded");

	chk_yend_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(wr_go) && $past(paddr) == `MBAG_OFF_Y_END
		|-> y_circ_end_ff == $past(pwdata[15:0]))
		else $error("Y end boundary not loaded");

	chk_idle_result: assert property (
		@(posedge pclk) disable iff (!presetn)
		!$past(xr_req.valid) |-> !xr_res_ff.valid && !xr_res_ff.wb_en &&
		!xr_res_ff.wrapped)
		else $error("X read result without request");

	chk_apb_one_wait: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready_ff |=> pready_ff)
		else $error("apb answer late");

	chk_pready_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready_ff |=> !pready_ff)
		else $error("apb ready held too long");

	chk_err_with_ready: assert property (
		@(posedge pclk) disable iff (!presetn)
		pslverr_ff |-> pready_ff)
		else $error("apb error without ready");
endmodule
`default_nettype wire

// ### hw/mbag_defines.svh
// constants for the modulo and bit-reversed address generator
//
// What this block does
// - four 16-bit circular start/end boundary registers
// - Y circular addresses always have bit zero clear
// - length is end minus start plus one, up to 32K
// - X circular: field 3:0 not 15, bit 15 set
// - Y circular: field 7:4 not 15, bit 14 set
// - any working pointer may be circular
// - compare beyond bounds, not only equality
// - write back only on pre/post modify
// - bit reversal only in X write unit
// - only the modifier is bit reversed
// - reversal needs field not 15, enable, increment
// - 15-bit pivot modifier scaled to bytes
// - other accesses fall back to normal or circular addresses
// - reversal: pointer plus pivot, offset ignored, even
// - reversal beats circular in X write only
// - 16-entry walk visits bit-reversed indices
`ifndef MBAG_DEFINES_SVH
`define MBAG_DEFINES_SVH

`define MBAG_AW            16
`define MBAG_PTR_NONE      4'hF
// register byte offsets
`define MBAG_OFF_MODE_CTL  8'h00
`define MBAG_OFF_BREV_CTL  8'h04
`define MBAG_OFF_X_START   8'h08
`define MBAG_OFF_X_END     8'h0C
`define MBAG_OFF_Y_START   8'h10
`define MBAG_OFF_Y_END     8'h14
`define MBAG_OFF_STAT_X    8'h18
`define MBAG_OFF_STAT_Y    8'h1C
// field positions in address_mode_control
`define MBAG_X_SEL_LSB     0
`define MBAG_Y_SEL_LSB     4
`define MBAG_B_SEL_LSB     8
`define MBAG_Y_EN_BIT      14
`define MBAG_X_EN_BIT      15
// field positions in bit_reverse_control
`define MBAG_REV_EN_BIT    15
// reset values: all pointer selects parked on 15, everything off
`define MBAG_RST_MODE_CTL  16'h0FFF
`define MBAG_RST_BREV_CTL  16'h0000
`define MBAG_RST_BOUND     16'h0000

`endif

// ### hw/mbag_pkg.sv
// types shared by the address generator files
`include "mbag_defines.svh"
package mbag_pkg;
	// addressing mode of one effective address request
	typedef enum logic [2:0] {
		MD_INDIRECT,
		MD_POST_INC,
		MD_POST_DEC,
		MD_PRE_INC,
		MD_PRE_DEC,
		MD_REG_OFFSET
	} mbag_mode_t;

	typedef struct packed {
		logic                   valid;
		mbag_mode_t             mode;
		logic [3:0]             ptr_sel;
		logic [`MBAG_AW-1:0]    ptr;
		logic [`MBAG_AW-1:0]    offset;
		logic                   word;
	} mbag_req_t;

	typedef struct packed {
		logic                   valid;
		logic [`MBAG_AW-1:0]    effective_addr;
		logic                   wb_en;
		logic [`MBAG_AW-1:0]    wb_val;
		logic                   wrapped;
		logic                   brev;
	} mbag_res_t;
endpackage

// ### hw/mbag_agu_lane.sv
// one address unit lane: circular correction and bit-reversed step
`timescale 1ns/10ps
`default_nettype none
`include "mbag_defines.svh"
module mbag_agu_lane #(
	parameter bit EVEN_ONLY = 1'b0,
	parameter bit HAS_BREV  = 1'b0
) (
	input  wire mbag_pkg::mbag_req_t  req,
	input  wire logic                 circ_on,
	input  wire logic [3:0]           circ_sel,
	input  wire logic [15:0]          circ_lo,
	input  wire logic [15:0]          circ_hi,
	input  wire logic                 rev_on,
	input  wire logic [3:0]           rev_sel,
	input  wire logic [14:0]          pivot_modifier,
	output var mbag_pkg::mbag_res_t   res
);
	function automatic logic [15:0] flip16(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++)
			r[i] = v[15-i];
		return r;
	endfunction

	// reverse-carry add: carries run from msb downward
	function automatic logic [15:0] rev_add(input logic [15:0] a,
		input logic [15:0] b);
		return flip16(flip16(a) + flip16(b));
	endfunction

	logic        word_eff;
	logic [15:0] step;
	logic [15:0] sum;
	logic        up;
	logic [16:0] len;
	logic        brev_act;
	logic        circ_act;
	logic [15:0] nval;
	logic        wrap;
	logic        pre_like;

	// step, direction and raw sum
	always_comb
	begin
		word_eff = req.word | EVEN_ONLY;
		up       = 1'b1;
		case (req.mode)
			mbag_pkg::MD_POST_INC, mbag_pkg::MD_PRE_INC:
				step = word_eff ? 16'h0002 : 16'h0001;
			mbag_pkg::MD_POST_DEC, mbag_pkg::MD_PRE_DEC:
			begin
				step = word_eff ? 16'hFFFE : 16'hFFFF;
				up   = 1'b0;
			end
			mbag_pkg::MD_REG_OFFSET:
			begin
				step = req.offset;
				up   = ~req.offset[15];
			end
			default:
				step = 16'h0000;
		endcase
		sum = req.ptr + step;
	end

	// mode gating; reversal wins over circular in this lane
	always_comb
	begin
		brev_act = HAS_BREV && rev_on && rev_sel != `MBAG_PTR_NONE &&
			req.ptr_sel == rev_sel && req.word &&
			(req.mode == mbag_pkg::MD_PRE_INC ||
			req.mode == mbag_pkg::MD_POST_INC);
		circ_act = circ_on && circ_sel != `MBAG_PTR_NONE &&
			req.ptr_sel == circ_sel && !brev_act &&
			req.mode != mbag_pkg::MD_INDIRECT;
		len = {1'b0, circ_hi} - {1'b0, circ_lo} + 17'h00001;
	end

	// corrected next address
	always_comb
	begin
		wrap = 1'b0;
		nval = sum;
		if (brev_act)
			// offset ignored, pivot scaled words to bytes
			nval = rev_add(req.ptr, {pivot_modifier, 1'b0}) &
				16'hFFFE;
		else if (circ_act && up && sum > circ_hi)
		begin
			nval = sum - len[15:0];
			wrap = 1'b1;
		end
		else if (circ_act && !up && sum < circ_lo)
		begin
			nval = sum + len[15:0];
			wrap = 1'b1;
		end
	end

	// effective address and write-back selection
	always_comb
	begin
		pre_like = req.mode == mbag_pkg::MD_PRE_INC ||
			req.mode == mbag_pkg::MD_PRE_DEC ||
			req.mode == mbag_pkg::MD_REG_OFFSET;
		res.valid          = req.valid;
		res.effective_addr = pre_like ? nval : req.ptr;
		res.wb_en          = req.valid &&
			req.mode != mbag_pkg::MD_INDIRECT &&
			req.mode != mbag_pkg::MD_REG_OFFSET;
		res.wb_val         = nval;
		res.wrapped        = req.valid && wrap;
		res.brev           = req.valid && brev_act;
		if (EVEN_ONLY || brev_act)
		begin
			res.effective_addr[0] = 1'b0;
			res.wb_val[0]         = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### sim/mbag_core_model.sv
// processor side model issuing address requests into the three lanes
`timescale 1ns/10ps
`default_nettype none
module mbag_core_model (
	input  wire logic                pclk,
	output var  mbag_pkg::mbag_req_t xr_req,
	output var  mbag_pkg::mbag_req_t xw_req,
	output var  mbag_pkg::mbag_req_t y_req,
	input  wire mbag_pkg::mbag_res_t xr_res,
	input  wire mbag_pkg::mbag_res_t xw_res,
	input  wire mbag_pkg::mbag_res_t y_res
);
	// lanes start idle so nothing is taken during reset
	initial
	begin
		xr_req = '0;
		xw_req = '0;
		y_req  = '0;
	end

	// one request per call, held for the taking edge, result one edge on
	// a call made right after an apb access starts on the next edge, never the same edge
	task automatic issue(
		input  int                  lane,
		input  mbag_pkg::mbag_req_t q,
		output mbag_pkg::mbag_res_t r
	);
		@(posedge pclk);
		case (lane)
			0: xr_req <= q;
			1: xw_req <= q;
			default: y_req <= q;
		endcase
		@(posedge pclk);
		xr_req <= '0;
		xw_req <= '0;
		y_req  <= '0;
		#1;
		r = (lane == 0) ? xr_res : (lane == 1) ? xw_res : y_res;
	endtask
endmodule
`default_nettype wire

// ### sim/modulo_bitrev_address_gen_tb.sv
// self-checking bench for the modulo and bit-reversed address generator
`timescale 1ns/10ps
`default_nettype none
`include "mbag_defines.svh"
module modulo_bitrev_address_gen_tb;
	logic                pclk;
	logic                presetn;
	logic [7:0]          paddr;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	mbag_pkg::mbag_req_t xr_req;
	mbag_pkg::mbag_req_t xw_req;
	mbag_pkg::mbag_req_t y_req;
	mbag_pkg::mbag_res_t xr_res;
	mbag_pkg::mbag_res_t xw_res;
	mbag_pkg::mbag_res_t y_res;
	int                  err_total = 0;
	int                  check_count = 0;
	int                  cyc = 0;
	logic [31:0]         rd;
	logic                re;

	mbag_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.xr_req(xr_req), .xw_req(xw_req), .y_req(y_req),
		.xr_res(xr_res), .xw_res(xw_res), .y_res(y_res));

	mbag_core_model core_u (.pclk(pclk), .xr_req(xr_req),
		.xw_req(xw_req), .y_req(y_req), .xr_res(xr_res),
		.xw_res(xw_res), .y_res(y_res));

	// 125 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// hang guard, far above the roughly 140 cycles the tests need
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// apb cycle; waits for pready, no fixed latency assumed
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		re = pslverr;
		if (n >= 20)
			chk(36'h0, 36'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// one lane request; write-back value only judged when enabled
	task automatic run(input int l, input mbag_pkg::mbag_mode_t m,
		input logic [3:0] s, input logic [15:0] p, input logic [15:0] o,
		input logic w, input logic [35:0] e);
		mbag_pkg::mbag_res_t r;
		core_u.issue(l, '{1'b1, m, s, p, o, w}, r);
		chk({r.valid, r.effective_addr, r.wb_en,
			(r.wb_en === 1'b1) ? r.wb_val : 16'h0000, r.wrapped, r.brev}, e);
	endtask

	function automatic logic [3:0] rv(input logic [3:0] a);
		return {a[0], a[1], a[2], a[3]};
	endfunction

	task automatic test_regs();
		apb(`MBAG_OFF_MODE_CTL, 1'b0, 32'h0);
		chk({re, rd}, {1'b0, 32'h0000_0FFF});
		apb(`MBAG_OFF_BREV_CTL, 1'b0, 32'h0);
		chk({re, rd}, {1'b0, 32'h0});
		apb(`MBAG_OFF_X_END, 1'b1, 32'h0000_ABCD);
		apb(`MBAG_OFF_X_END, 1'b0, 32'h0);
		chk({re, rd}, {1'b0, 32'h0000_ABCD});
		apb(8'h40, 1'b0, 32'h0);
		chk({re, rd}, {1'b1, 32'h0});
		apb(`MBAG_OFF_STAT_X, 1'b1, 32'h0000_FFFF);
		chk({re, rd}, {1'b0, 32'h0});
		apb(`MBAG_OFF_STAT_Y, 1'b0, 32'h0);
		chk({re, rd}, {1'b0, 32'h0});
		$display("test regs done");
	endtask

	task automatic test_circ();
		apb(`MBAG_OFF_X_START, 1'b1, 32'h0000_1000);
		apb(`MBAG_OFF_X_END, 1'b1, 32'h0000_100F);
		apb(`MBAG_OFF_MODE_CTL, 1'b1, 32'h0000_8FF2);
		run(0, mbag_pkg::MD_POST_INC, 4'h2, 16'h100E, 16'h0, 1'b1,
			{1'b1, 16'h100E, 1'b1, 16'h1000, 2'b10});
		run(1, mbag_pkg::MD_REG_OFFSET, 4'h2, 16'h100C, 16'h6, 1'b1,
			{1'b1, 16'h1002, 1'b0, 16'h0000, 2'b10});
		run(0, mbag_pkg::MD_POST_DEC, 4'h2, 16'h1000, 16'h0, 1'b1,
			{1'b1, 16'h1000, 1'b1, 16'h100E, 2'b10});
		run(0, mbag_pkg::MD_POST_INC, 4'h3, 16'h100E, 16'h0, 1'b1,
			{1'b1, 16'h100E, 1'b1, 16'h1010, 2'b00});
		apb(`MBAG_OFF_MODE_CTL, 1'b1, 32'h0000_0FF2);
		run(0, mbag_pkg::MD_POST_INC, 4'h2, 16'h100E, 16'h0, 1'b1,
			{1'b1, 16'h100E, 1'b1, 16'h1010, 2'b00});
		$display("test circ done");
	endtask

	task automatic test_y();
		apb(`MBAG_OFF_Y_START, 1'b1, 32'h0000_2000);
		apb(`MBAG_OFF_Y_END, 1'b1, 32'h0000_2007);
		apb(`MBAG_OFF_MODE_CTL, 1'b1, 32'h0000_4F5F);
		run(2, mbag_pkg::MD_POST_INC, 4'h5, 16'h2006, 16'h0, 1'b0,
			{1'b1, 16'h2006, 1'b1, 16'h2000, 2'b10});
		run(2, mbag_pkg::MD_INDIRECT, 4'h5, 16'h2003, 16'h0, 1'b0,
			{1'b1, 16'h2002, 1'b0, 16'h0000, 2'b00});
		$display("test y done");
	endtask

	// 16-word buffer at 0, pivot of half the size, circular on too
	task automatic test_brev();
		logic [15:0] p;
		logic [15:0] n;
		apb(`MBAG_OFF_X_START, 1'b1, 32'h0);
		apb(`MBAG_OFF_X_END, 1'b1, 32'h0000_000F);
		apb(`MBAG_OFF_BREV_CTL, 1'b1, 32'h0000_8008);
		apb(`MBAG_OFF_MODE_CTL, 1'b1, 32'h0000_81F1);
		for (int k = 0; k < 16; k++)
		begin
			p = {11'h000, rv(k[3:0]), 1'b0};
			n = {11'h000, rv(k[3:0] + 4'h1), 1'b0};
			run(1, mbag_pkg::MD_POST_INC, 4'h1, p, 16'h40, 1'b1,
				{1'b1, p, 1'b1, n, 2'b01});
		end
		run(1, mbag_pkg::MD_PRE_INC, 4'h1, 16'h0010, 16'h6, 1'b1,
			{1'b1, 16'h0008, 1'b1, 16'h0008, 2'b01});
		run(1, mbag_pkg::MD_POST_INC, 4'h1, 16'h0004, 16'h0, 1'b0,
			{1'b1, 16'h0004, 1'b1, 16'h0005, 2'b00});
		run(1, mbag_pkg::MD_PRE_DEC, 4'h1, 16'h0004, 16'h0, 1'b1,
			{1'b1, 16'h0002, 1'b1, 16'h0002, 2'b00});
		run(0, mbag_pkg::MD_POST_INC, 4'h1, 16'h000E, 16'h0, 1'b1,
			{1'b1, 16'h000E, 1'b1, 16'h0000, 2'b10});
		$display("test brev done");
	endtask

	initial
	begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_circ();
		test_y();
		test_brev();
		finish_test();
	end
endmodule
`default_nettype wire
